//--- rtl/cdr_cfg.svh
// offsets, field positions and reset values of the console register bank
`ifndef CDR_CFG_SVH
`define CDR_CFG_SVH

// console slots: byte address bits 7:3 select a 64-bit slot, bits 2:0 the byte
`define CDR_SLOT_ADDR 5'h00
`define CDR_SLOT_DATA 5'h01
`define CDR_SLOT_BOOT 5'h03
`define CDR_SLOT_MUX 5'h04
`define CDR_SLOT_DISKC 5'h05
`define CDR_SLOT_DISKD 5'h06
`define CDR_SLOT_DEBUG_CONTROL_STATUS 5'h07
`define CDR_SLOT_BAR 5'h08
`define CDR_SLOT_BMR 5'h09
`define CDR_SLOT_TRACE 5'h0a
`define CDR_TRACE_POP_ADDR 8'h57

// field positions, vector index (bit 0 is the least significant bit)
`define CDR_MUX_LOOP_BIT 16
`define CDR_DEBUG_CONTROL_STATUS_BRK_BYTE 3'h1
`define CDR_DEBUG_CONTROL_STATUS_BRK_LSB 6
`define CDR_DEBUG_CONTROL_STATUS_TR_BYTE 3'h0
`define CDR_DEBUG_CONTROL_STATUS_TR_LSB 6
`define CDR_DEBUG_CONTROL_STATUS_CLR_BIT 0
`define CDR_BUS_IO_BIT 25

// boot instruction register io address, low 22 address bits
`define CDR_BOOT_IO_ADDR 22'h1_0000

// reset values
`define CDR_RST_36 36'h0_0000_0000
`define CDR_RST_64 64'h0000_0000_0000_0000

// trace buffer
`define CDR_TRACE_AW 4
`define CDR_TRACE_DEPTH 5'h10

`endif

//--- rtl/cdr_pkg.sv
// types of the console register bank
package cdr_pkg;

    typedef enum logic [1:0] {
        BRK_OFF = 2'b00,
        BRK_MATCH = 2'b01,
        BRK_FULL = 2'b10,
        BRK_RSVD = 2'b11
    } cdr_brk_mode_t;

    typedef enum logic [1:0] {
        TR_OFF = 2'b00,
        TR_MATCH = 2'b01,
        TR_ALWAYS = 2'b10,
        TR_RSVD = 2'b11
    } cdr_trace_mode_t;

    typedef struct packed {
        logic valid;
        logic cpu;
        logic [35:0] addr;
    } cdr_bus_t;

    typedef struct packed {
        logic [17:0] pc;
        logic [35:0] ir;
    } cdr_trace_entry_t;

    // drive 0 lamp first so it lands in the highest lamp bit
    typedef struct packed {
        logic [7:0] card_state;
        logic [7:0] sd_fault_code;
        logic [7:0] sd_fault_detail;
        logic [7:0] disk_write_tally;
        logic [7:0] disk_read_tally;
        logic [0:7] drive_activity_lamp;
    } cdr_disk_dbg_t;

    typedef struct packed {
        logic [7:0] drive_enabled;
        logic [7:0] drive_present;
        logic [7:0] card_inserted;
        logic [7:0] write_protect;
    } cdr_disk_ctl_t;

endpackage : cdr_pkg

//--- rtl/cdr_bank.sv
// console-side register bank with breakpoint and instruction trace logic
`timescale 1ns/1ps
`default_nettype none
`include "cdr_cfg.svh"

// Summary of operation
// - data register feeds writes, captures read data
// - address register drives backplane address unchanged
// - boot instruction readable at io address
// - boot instruction accepts any value
// - loopback bit joins transmit to receive
// - carrier sense shows in modem status high
// - ring indication shows in modem status low
// - unused control bits are plain storage
// - disk control holds four per-drive fields
// - disk debug reports state, faults, tallies
// - disk debug zeros middle, shows drive lamps
// - breakpoint mode off, match, or full
// - trace mode off, on match, or always
// - capturing flag while acquiring, cleared by clear
// - full flag at capacity, zero after reset
// - empty flag when vacant, one after reset
// - clear bit empties buffer, reads zero
// - halt processor on masked address match
// - only processor cycles, never direct memory access
// - breakpoint address holds flags and address
// - mask bit set includes bit in compare
// - trace fifo stores pc and ir; read advances
// - little-endian bytes, one 64-bit slot each
// - console writes synchronized, reads synchronized and registered
module cdr_bank
    import cdr_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // console microcontroller bus
    input wire logic [7:0] con_addr_i,
    input wire logic [7:0] con_data_i,
    output logic [7:0] con_data_o,
    output logic con_data_oe_o,
    input wire logic con_rd_n_i,
    input wire logic con_wr_n_i,
    input wire logic con_ble_n_i,
    input wire logic con_bhe_n_i,
    // console transaction engine
    input wire logic xfer_done_i,
    input wire logic xfer_read_i,
    input wire logic [35:0] xfer_rdata_i,
    output logic [35:0] con_bus_addr_o,
    output logic [35:0] con_wdata_o,
    // backplane watch and boot instruction io read
    input wire cdr_bus_t bus_i,
    input wire logic io_rd_i,
    output logic [35:0] io_rdata_o,
    output logic io_ack_o,
    output logic brk_halt_o,
    // executed instruction stream
    input wire logic instr_exec_i,
    input wire cdr_trace_entry_t trace_i,
    // terminal multiplexer
    input wire logic mux_txd_i,
    input wire logic line_rxd_i,
    output logic mux_rxd_o,
    output logic line_txd_o,
    output logic [15:0] modem_status_o,
    // disk controller
    input wire cdr_disk_dbg_t disk_dbg_i,
    output var cdr_disk_ctl_t disk_ctl_o
);

    function automatic logic [63:0] cdr_put_byte(input logic [63:0] old,
                                                 input logic [2:0] k,
                                                 input logic [7:0] d);
        logic [63:0] v;
        v = old;
        v[{k, 3'b000} +: 8] = d;
        return v;
    endfunction : cdr_put_byte

    function automatic logic [7:0] cdr_get_byte(input logic [63:0] v,
                                                input logic [2:0] k);
        return v[{k, 3'b000} +: 8];
    endfunction : cdr_get_byte

    logic [1:0] rst_q;
    logic rst_n;
    logic [19:0] pin_meta;
    logic [19:0] pin_s;
    logic rd_prev;
    logic wr_prev;
    logic [1:0] rxd_q;
    logic [35:0] addr_r;
    logic [35:0] data_r;
    logic [35:0] boot_r;
    logic [63:0] mux_r;
    logic [63:0] diskc_r;
    logic [35:0] bar_r;
    logic [35:0] bmr_r;
    cdr_brk_mode_t brk_mode_r;
    cdr_trace_mode_t trace_mode_r;
    logic capturing_r;
    logic full_r;
    logic empty_r;
    logic armed_r;
    logic stop_r;
    logic [`CDR_TRACE_AW:0] count_r;
    logic [`CDR_TRACE_AW:0] count_nxt;
    logic [`CDR_TRACE_AW-1:0] wr_ptr_r;
    logic [`CDR_TRACE_AW-1:0] rd_ptr_r;
    cdr_trace_entry_t trace_mem [0:(1 << `CDR_TRACE_AW)-1];
    logic [7:0] s_addr;
    logic [7:0] s_data;
    logic s_rd_n;
    logic s_wr_n;
    logic s_ble_n;
    logic s_bhe_n;
    logic [4:0] slot;
    logic [2:0] bsel;
    logic wr_stb;
    logic pop;
    logic push;
    logic clr;
    logic match;
    logic cpu_match;
    logic trig;
    logic boot_hit;
    logic [63:0] slot_val;
    logic [35:0] debug_control_status_val;

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // console pins are asynchronous; only the second stage is used
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 20'hf_0000;
            pin_s <= 20'hf_0000;
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
            rxd_q <= 2'b11;
        end
        else if (ce_i)
        begin
            pin_meta <= {con_rd_n_i, con_wr_n_i, con_ble_n_i, con_bhe_n_i,
                         con_addr_i, con_data_i};
            pin_s <= pin_meta;
            rd_prev <= s_rd_n;
            wr_prev <= s_wr_n;
            rxd_q <= {rxd_q[0], line_rxd_i};
        end
    end
    assign {s_rd_n, s_wr_n, s_ble_n, s_bhe_n, s_addr, s_data} = pin_s;
    assign slot = s_addr[7:3];
    assign bsel = s_addr[2:0];
    // one write per falling write strobe with a byte lane enabled
    assign wr_stb = ce_i && wr_prev && !s_wr_n && (!s_ble_n || !s_bhe_n);
    assign pop = ce_i && !rd_prev && s_rd_n && (s_addr == `CDR_TRACE_POP_ADDR)
                 && !empty_r;
    assign clr = wr_stb && (slot == `CDR_SLOT_DEBUG_CONTROL_STATUS) && (bsel == `CDR_DEBUG_CONTROL_STATUS_TR_BYTE)
                 && s_data[`CDR_DEBUG_CONTROL_STATUS_CLR_BIT];

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            addr_r <= `CDR_RST_36;
        else if (wr_stb && slot == `CDR_SLOT_ADDR)
            addr_r <= 36'(cdr_put_byte(64'(addr_r), bsel, s_data));
    end
    assign con_bus_addr_o = addr_r;

    // returned read data wins: software must not write while busy
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            data_r <= `CDR_RST_36;
        else if (ce_i && xfer_done_i && xfer_read_i)
            data_r <= xfer_rdata_i;
        else if (wr_stb && slot == `CDR_SLOT_DATA)
            data_r <= 36'(cdr_put_byte(64'(data_r), bsel, s_data));
    end
    assign con_wdata_o = data_r;

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            boot_r <= `CDR_RST_36;
        else if (wr_stb && slot == `CDR_SLOT_BOOT)
            boot_r <= 36'(cdr_put_byte(64'(boot_r), bsel, s_data));
    end

    assign boot_hit = io_rd_i && bus_i.addr[`CDR_BUS_IO_BIT]
                      && (bus_i.addr[21:0] == `CDR_BOOT_IO_ADDR);
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_ack_o <= 1'b0;
            io_rdata_o <= `CDR_RST_36;
        end
        else if (ce_i)
        begin
            io_ack_o <= boot_hit;
            io_rdata_o <= boot_hit ? boot_r : `CDR_RST_36;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            mux_r <= `CDR_RST_64;
        else if (wr_stb && slot == `CDR_SLOT_MUX)
            mux_r <= cdr_put_byte(mux_r, bsel, s_data);
    end
    assign modem_status_o = mux_r[15:0];

    // line held idle while looped so nothing leaks to the far end
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_rxd_o <= 1'b1;
            line_txd_o <= 1'b1;
        end
        else if (ce_i)
        begin
            mux_rxd_o <= mux_r[`CDR_MUX_LOOP_BIT] ? mux_txd_i : rxd_q[1];
            line_txd_o <= mux_r[`CDR_MUX_LOOP_BIT] ? 1'b1 : mux_txd_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            diskc_r <= `CDR_RST_64;
        else if (wr_stb && slot == `CDR_SLOT_DISKC)
            diskc_r <= cdr_put_byte(diskc_r, bsel, s_data);
    end
    assign disk_ctl_o = diskc_r[31:0];

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bar_r <= `CDR_RST_36;
            bmr_r <= `CDR_RST_36;
        end
        else if (wr_stb)
        begin
            if (slot == `CDR_SLOT_BAR)
                bar_r <= 36'(cdr_put_byte(64'(bar_r), bsel, s_data));
            if (slot == `CDR_SLOT_BMR)
                bmr_r <= 36'(cdr_put_byte(64'(bmr_r), bsel, s_data));
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brk_mode_r <= BRK_OFF;
            trace_mode_r <= TR_OFF;
        end
        else if (wr_stb && slot == `CDR_SLOT_DEBUG_CONTROL_STATUS)
        begin
            if (bsel == `CDR_DEBUG_CONTROL_STATUS_BRK_BYTE)
                brk_mode_r <= cdr_brk_mode_t'(s_data[`CDR_DEBUG_CONTROL_STATUS_BRK_LSB +: 2]);
            if (bsel == `CDR_DEBUG_CONTROL_STATUS_TR_BYTE)
                trace_mode_r <= cdr_trace_mode_t'(s_data[`CDR_DEBUG_CONTROL_STATUS_TR_LSB +: 2]);
        end
    end

    // mask bit set keeps that bit in the compare
    assign match = ~|((bus_i.addr ^ bar_r) & bmr_r);
    assign cpu_match = bus_i.valid && bus_i.cpu && match;

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            brk_halt_o <= 1'b0;
        else if (ce_i)
            brk_halt_o <= ((brk_mode_r == BRK_MATCH) && cpu_match)
                          || ((brk_mode_r == BRK_FULL) && full_r);
    end

    // reserved modes behave as off
    assign trig = !stop_r && ((trace_mode_r == TR_ALWAYS)
                  || ((trace_mode_r == TR_MATCH) && (armed_r || cpu_match)));
    assign push = ce_i && !clr && trig && instr_exec_i && !full_r;
    assign count_nxt = clr ? '0 : (count_r + (`CDR_TRACE_AW+1)'(push)
                                  - (`CDR_TRACE_AW+1)'(pop));

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed_r <= 1'b0;
            stop_r <= 1'b0;
        end
        else if (clr)
        begin
            armed_r <= 1'b0;
            stop_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (trace_mode_r == TR_MATCH && cpu_match)
                armed_r <= 1'b1;
            if (count_nxt == `CDR_TRACE_DEPTH)
                stop_r <= 1'b1;
        end
    end

    // clear wins over acquisition in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
            capturing_r <= 1'b0;
        end
        else if (ce_i)
        begin
            count_r <= count_nxt;
            full_r <= (count_nxt == `CDR_TRACE_DEPTH);
            empty_r <= (count_nxt == '0);
            capturing_r <= !clr && trig && (count_nxt != `CDR_TRACE_DEPTH);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else if (clr)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // storage only, no reset needed
    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            trace_mem[wr_ptr_r] <= trace_i;
    end

    // clear bit reads as zero
    assign debug_control_status_val = {20'h0_0000, brk_mode_r, 6'h00, trace_mode_r, 2'b00,
                       capturing_r, full_r, empty_r, 1'b0};

    always_comb
    begin
        slot_val = `CDR_RST_64;
        case (slot)
            `CDR_SLOT_ADDR: slot_val = 64'(addr_r);
            `CDR_SLOT_DATA: slot_val = 64'(data_r);
            `CDR_SLOT_BOOT: slot_val = 64'(boot_r);
            `CDR_SLOT_MUX: slot_val = mux_r;
            `CDR_SLOT_DISKC: slot_val = diskc_r;
            `CDR_SLOT_DISKD: slot_val = {disk_dbg_i.card_state, disk_dbg_i.sd_fault_code,
                                        disk_dbg_i.sd_fault_detail,
                                        disk_dbg_i.disk_write_tally,
                                        disk_dbg_i.disk_read_tally, 16'h0000,
                                        disk_dbg_i.drive_activity_lamp};
            `CDR_SLOT_DEBUG_CONTROL_STATUS: slot_val = 64'(debug_control_status_val);
            `CDR_SLOT_BAR: slot_val = 64'(bar_r);
            `CDR_SLOT_BMR: slot_val = 64'(bmr_r);
            `CDR_SLOT_TRACE: slot_val = {10'h000, trace_mem[rd_ptr_r]};
            default: slot_val = `CDR_RST_64;
        endcase
    end

    // read path is pure decode; registering it costs one cycle of latency
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            con_data_o <= 8'h00;
            con_data_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            con_data_o <= cdr_get_byte(slot_val, bsel);
            con_data_oe_o <= !s_rd_n;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    property p_xfer_load;
        ce_i && xfer_done_i && xfer_read_i |=> con_wdata_o == $past(xfer_rdata_i);
    endproperty
    a_xfer_load: assert property (p_xfer_load) else $error("read data not captured");

    property p_boot_io;
        ce_i && boot_hit |=> io_ack_o && (io_rdata_o == $past(boot_r));
    endproperty
    a_boot_io: assert property (p_boot_io) else $error("boot word not returned");

    property p_loop;
        ce_i && mux_r[`CDR_MUX_LOOP_BIT] |=> mux_rxd_o == $past(mux_txd_i) && line_txd_o;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback path wrong");

    property p_brk_halt;
        ce_i && brk_mode_r == BRK_MATCH && cpu_match |=> brk_halt_o;
    endproperty
    a_brk_halt: assert property (p_brk_halt) else $error("no halt on match");

    property p_no_dma_halt;
        ce_i && brk_mode_r == BRK_MATCH && !(bus_i.valid && bus_i.cpu) |=> !brk_halt_o;
    endproperty
    a_no_dma_halt: assert property (p_no_dma_halt) else $error("halt without cpu cycle");

    property p_clear;
        clr |=> empty_r && !full_r && !capturing_r && count_r == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty buffer");

    property p_full_holds;
        ce_i && full_r && !pop && !clr |=> full_r && $stable(count_r);
    endproperty
    a_full_holds: assert property (p_full_holds) else $error("full buffer changed");

    property p_last_pop;
        ce_i && count_r == 5'h01 && pop && !push && !clr |=> empty_r ##1 (empty_r || $past(push));
    endproperty
    a_last_pop: assert property (p_last_pop) else $error("empty not set");

    property p_write_sync;
        wr_stb && slot == `CDR_SLOT_BOOT && bsel == 3'h0 |=> boot_r[7:0] == $past(s_data);
    endproperty
    a_write_sync: assert property (p_write_sync) else $error("console write lost");

endmodule : cdr_bank
`default_nettype wire

//--- bench/cdr_con_model.sv
// console microcontroller model: byte reads and writes on the 8-bit console bus
`timescale 1ns/1ps
`default_nettype none
module cdr_con_model (
    // clock
    input wire logic ref_clk_i,
    // console bus as seen at the pins
    input wire logic [7:0] bus_data_i,
    output logic [7:0] con_addr_o,
    output logic [7:0] con_data_o,
    output logic con_rd_n_o,
    output logic con_wr_n_o,
    output logic con_ble_n_o,
    output logic con_bhe_n_o
);
    initial
    begin
        con_addr_o = 8'h00;
        con_data_o = 8'h00;
        con_rd_n_o = 1'b1;
        con_wr_n_o = 1'b1;
        con_ble_n_o = 1'b1;
        con_bhe_n_o = 1'b1;
    end

    // strobes held 5 cycles low, 5 high: the bank only sees them after its synchroniser
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        con_addr_o = a;
        con_data_o = d;
        con_ble_n_o = a[0];
        con_bhe_n_o = ~a[0];
        con_wr_n_o = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        con_wr_n_o = 1'b1;
        con_ble_n_o = 1'b1;
        con_bhe_n_o = 1'b1;
        con_data_o = ~d;
        repeat (5) @(negedge ref_clk_i);
    endtask : wr_byte

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        con_addr_o = a;
        con_rd_n_o = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        d = bus_data_i;
        con_rd_n_o = 1'b1;
        repeat (5) @(negedge ref_clk_i);
    endtask : rd_byte
endmodule : cdr_con_model
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the console register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cdr_pkg::*;
;
    logic clk, rstn, rd_n, wr_n, ble_n, bhe_n, oe, done, rdx, io_rd, ack, halt, ex;
    logic txd, rxd, mrxd, ltxd, hs, as;
    logic [7:0] addr, mdat, dout, dbus;
    logic [15:0] modem;
    logic [35:0] xrd, badr, wdat, iord, rv;
    cdr_bus_t bus;
    cdr_trace_entry_t tr;
    cdr_disk_dbg_t ddbg;
    cdr_disk_ctl_t dctl;
    int num_errors = 0;
    int checked = 0;
    localparam logic [35:0] BAR = 36'h0_0201_2345;
    logic [7:0] rw [5] = '{8'h00, 8'h08, 8'h18, 8'h40, 8'h48};
    logic [35:0] ca [4] = '{BAR ^ 36'h5, BAR, BAR ^ 36'h10, BAR ^ 36'h8_0000_0000};
    logic [3:0] ccpu = 4'b1101;

    assign dbus = oe ? dout : mdat;

    cdr_bank DUT (
        .ref_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1),
        .con_addr_i(addr), .con_data_i(dbus), .con_data_o(dout), .con_data_oe_o(oe),
        .con_rd_n_i(rd_n), .con_wr_n_i(wr_n), .con_ble_n_i(ble_n), .con_bhe_n_i(bhe_n),
        .xfer_done_i(done), .xfer_read_i(rdx), .xfer_rdata_i(xrd),
        .con_bus_addr_o(badr), .con_wdata_o(wdat),
        .bus_i(bus), .io_rd_i(io_rd), .io_rdata_o(iord), .io_ack_o(ack), .brk_halt_o(halt),
        .instr_exec_i(ex), .trace_i(tr),
        .mux_txd_i(txd), .line_rxd_i(rxd), .mux_rxd_o(mrxd), .line_txd_o(ltxd),
        .modem_status_o(modem), .disk_dbg_i(ddbg), .disk_ctl_o(dctl));

    cdr_con_model u_con (.ref_clk_i(clk), .bus_data_i(dbus), .con_addr_o(addr),
        .con_data_o(mdat), .con_rd_n_o(rd_n), .con_wr_n_o(wr_n), .con_ble_n_o(ble_n),
        .con_bhe_n_o(bhe_n));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: mismatch got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] base, input logic [63:0] val, input int n);
        for (int i = 0; i < n; i++)
            u_con.wr_byte(base + 8'(i), val[8*i +: 8]);
    endtask : wr_reg

    task automatic chk_reg(input logic [7:0] base, input int n, input logic [63:0] exp);
        logic [7:0] b;
        logic [63:0] got;
        got = '0;
        for (int i = 0; i < n; i++)
        begin
            u_con.rd_byte(base + 8'(i), b);
            got[8*i +: 8] = b;
        end
        chk(got, exp);
    endtask : chk_reg

    // one backplane cycle, then watch halt and io answer for three cycles
    task automatic cyc(input logic [35:0] a, input logic cpu, input logic io, input logic x);
        hs = 1'b0;
        as = 1'b0;
        rv = '0;
        @(negedge clk);
        bus = '{valid: 1'b1, cpu: cpu, addr: a};
        io_rd = io;
        ex = x;
        @(negedge clk);
        bus = '{valid: 1'b0, cpu: 1'b0, addr: ~a};
        io_rd = 1'b0;
        ex = 1'b0;
        tr = ~tr;
        repeat (3)
        begin
            if (halt === 1'b1)
                hs = 1'b1;
            if (ack === 1'b1)
            begin
                as = 1'b1;
                rv = iord;
            end
            @(negedge clk);
        end
    endtask : cyc

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        #200000;
        num_errors++;
        $display("Error %0t: watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        rstn = 1'b0;
        done = 1'b0;
        rdx = 1'b0;
        xrd = '0;
        bus = '0;
        io_rd = 1'b0;
        ex = 1'b0;
        tr = '0;
        txd = 1'b1;
        rxd = 1'b1;
        ddbg = '0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        chk_reg(8'h38, 5, 64'h2);
        chk(modem, 16'h0);
        $display("reset test done");
        for (int i = 0; i < 5; i++)
            wr_reg(rw[i], 64'hffee_dda5_6004_0200 + 64'(i), 8);
        for (int i = 0; i < 5; i++)
            chk_reg(rw[i], 8, 64'h5_6004_0200 + 64'(i));
        chk(badr, 36'h5_6004_0200);
        chk(wdat, 36'h5_6004_0201);
        $display("register test done");
        @(negedge clk);
        done = 1'b1;
        rdx = 1'b1;
        xrd = 36'h9_8765_4321;
        @(negedge clk);
        done = 1'b0;
        rdx = 1'b0;
        xrd = 36'h1_1111_1111;
        @(negedge clk);
        chk(wdat, 36'h9_8765_4321);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        @(negedge clk);
        chk_reg(8'h08, 5, 64'h9_8765_4321);
        cyc(36'h0_0201_0000, 1'b1, 1'b1, 1'b0);
        chk(rv, 36'h5_6004_0202);
        chk(as, 64'h1);
        cyc(36'h0_0201_0001, 1'b1, 1'b1, 1'b0);
        chk(rv, 36'h0);
        chk(as, 64'h0);
        $display("transfer test done");
        wr_reg(8'h20, 64'hc3a5_0000_1234_5a3c, 8);
        chk(modem, 16'h5a3c);
        chk_reg(8'h20, 8, 64'hc3a5_0000_1234_5a3c);
        for (int lp = 0; lp < 2; lp++)
        begin
            u_con.wr_byte(8'h22, {7'h1a, 1'(lp)});
            for (int k = 0; k < 2; k++)
            begin
                txd = 1'(k);
                rxd = 1'(1 - k);
                repeat (4) @(negedge clk);
                chk(mrxd, 64'((lp != 0) ? k : 1 - k));
                chk(ltxd, 64'((lp != 0) ? 1 : k));
            end
        end
        $display("mux test done");
        wr_reg(8'h28, 64'h0123_4567_89ab_cdef, 8);
        chk(dctl, 32'h89ab_cdef);
        chk_reg(8'h28, 8, 64'h0123_4567_89ab_cdef);
        ddbg = 48'h8877_6655_44a1;
        u_con.wr_byte(8'h37, 8'h00);
        chk_reg(8'h30, 8, 64'h8877_6655_4400_00a1);
        chk_reg(8'h10, 8, 64'h0);
        chk_reg(8'hf8, 8, 64'h0);
        $display("disk test done");
        wr_reg(8'h40, BAR, 5);
        wr_reg(8'h48, 64'hf_ffff_fff0, 5);
        u_con.wr_byte(8'h39, 8'h40);
        for (int i = 0; i < 4; i++)
        begin
            cyc(ca[i], ccpu[i], 1'b0, 1'b0);
            chk(hs, 64'(i == 0));
        end
        for (int m = 0; m < 2; m++)
        begin
            u_con.wr_byte(8'h39, {2'(3 * m), 6'h00});
            cyc(BAR, 1'b1, 1'b0, 1'b0);
            chk(hs, 64'h0);
        end
        $display("breakpoint test done");
        u_con.wr_byte(8'h39, 8'h80);
        u_con.wr_byte(8'h38, 8'h40);
        cyc(BAR ^ 36'h10, 1'b1, 1'b0, 1'b1);
        chk_reg(8'h38, 1, 64'h42);
        // seventeenth push must be dropped once the buffer is full
        for (int k = 0; k < 17; k++)
        begin
            tr = '{pc: 18'h1_0000 + 18'(k), ir: 36'h5_6000_0000 + 36'(k)};
            cyc((k == 0) ? BAR : BAR ^ 36'h10, 1'b1, 1'b0, 1'b1);
            if (k == 0)
                chk_reg(8'h38, 1, 64'h48);
        end
        chk_reg(8'h38, 1, 64'h44);
        cyc(BAR ^ 36'h10, 1'b1, 1'b0, 1'b0);
        chk(hs, 64'h1);
        for (int k = 0; k < 16; k++)
            chk_reg(8'h50, 8, {10'h000, 18'h1_0000 + 18'(k), 36'h5_6000_0000 + 36'(k)});
        chk_reg(8'h38, 1, 64'h42);
        cyc(BAR ^ 36'h10, 1'b1, 1'b0, 1'b0);
        chk(hs, 64'h0);
        // capture stays stopped after full until cleared: clear along with the mode change
        u_con.wr_byte(8'h38, 8'h81);
        for (int k = 0; k < 3; k++)
            cyc(BAR ^ 36'h10, 1'b1, 1'b0, 1'b1);
        chk_reg(8'h38, 1, 64'h88);
        u_con.wr_byte(8'h38, 8'h01);
        chk_reg(8'h38, 1, 64'h02);
        u_con.wr_byte(8'h38, 8'hc0);
        cyc(BAR ^ 36'h10, 1'b1, 1'b0, 1'b1);
        chk_reg(8'h38, 1, 64'hc2);
        $display("trace test done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
